// ===== sps_pkg.sv
// Purpose: Shared constants and types for the byte-wide serial port.
// Assumes: One clock (ref_clk, 250 MHz); CPU bus clock is the same clock.
// Notes:   Each rule below is tagged at the logic that carries it out.
package sps_pkg;

  // Register offsets; the bus carries only the two low address bits.
  localparam logic [7:0] CTRL_OFFSET   = 8'h20;
  localparam logic [7:0] STATUS_OFFSET = 8'h21;
  localparam logic [7:0] DATA_OFFSET   = 8'h22;

  // Control register fields.
  localparam int CTRL_IRQ_EN_BIT  = 7;
  localparam int CTRL_SYS_EN_BIT  = 6;
  localparam int CTRL_MASTER_BIT  = 4;
  localparam int CTRL_CLOCK_POLARITY_BIT    = 3;
  localparam int CTRL_CLOCK_PHASE_BIT    = 2;
  localparam int CTRL_RATE_HI_BIT = 1;
  localparam int CTRL_RATE_LO_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h04;

  // Status register fields.
  localparam int STAT_DONE_BIT  = 7;
  localparam int STAT_WRITE_COLLISION_FLAG_BIT  = 6;
  localparam int STAT_MODE_FAULT_FLAG_BIT  = 4;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // Byte size, index of the last serial clock edge of a byte, and receive FIFO depth.
  localparam int BYTE_BITS = 8;
  localparam logic [4:0] LAST_EDGE = 5'h0f;
  localparam int RX_FIFO_DEPTH = 32;

  // Bus clock divide ratios per rate code.
  localparam logic [5:0] DIV_CODE0 = 6'h02;
  localparam logic [5:0] DIV_CODE1 = 6'h04;
  localparam logic [5:0] DIV_CODE2 = 6'h10;
  localparam logic [5:0] DIV_CODE3 = 6'h20;

  // CPU register access request.
  typedef struct packed {
    logic       sel;
    logic [1:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sps_bus_req_type;

  // Master sequencer states.
  typedef enum logic [0:0] {
    MST_IDLE = 1'b0,
    MST_XFER = 1'b1
  } sps_mst_state_type;

endpackage

// ===== sps_sync.sv
// Purpose: Two-flop synchroniser for asynchronous pin levels.
// Assumes: Inputs are slow levels relative to ref_clk.
// Notes:   Only the second stage is visible to other logic.
`timescale 1ns/1ps
`default_nettype none
module sps_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  // Levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage to keep metastability contained.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule // sps_sync
`default_nettype wire

// ===== sps_fifo.sv
// Purpose: Flip-flop FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   Full and empty come from an occupancy count.
`timescale 1ns/1ps
`default_nettype none
module sps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Storage is written only on an accepted push.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // sps_fifo
`default_nettype wire

// ===== sps_port.sv
// Purpose: Byte-wide synchronous serial port, master or slave, with CPU registers.
// Assumes: ref_clk is the bus clock; pins arrive asynchronously.
// Notes:   Bytes stream out via a FIFO; synced MISO limits master reads to rates 10 and 11.
`timescale 1ns/1ps
`default_nettype none
module sps_port
  import sps_pkg::*;
#(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            arst_n,
  // CPU register access
  input  wire sps_bus_req_type busReq,
  output logic      [7:0]      regRdata,
  input  wire logic            cpuIrqMask,
  output logic                 irqReq,
  // Serial pins: three signals each for two-way pins
  input  wire logic            sckIn,
  output logic                 sckOut,
  output logic                 sckOe,
  input  wire logic            mosiIn,
  output logic                 mosiOut,
  output logic                 mosiOe,
  input  wire logic            misoIn,
  output logic                 misoOut,
  output logic                 misoOe,
  input  wire logic            slaveSelectIn,
  output logic                 portCLowPinsSel,
  // Received byte stream
  output logic                 rxStreamValid,
  input  wire logic            rxStreamReady,
  output logic      [7:0]      rxStreamData
);

  // Half-period of SCK in bus clocks, minus one, for a rate code.
  function automatic logic [5:0] halfPeriodLast(input logic [1:0] code);
    logic [5:0] div;
    div = DIV_CODE0;
    case (code)
      2'b00: div = DIV_CODE0;
      2'b01: div = DIV_CODE1;
      2'b10: div = DIV_CODE2;
      default: div = DIV_CODE3;
    endcase
    return (div >> 1) - 6'h01;
  endfunction

  // Control fields.
  logic              irqEnable;
  logic              sysEnable;
  logic              masterSel;
  logic              clockPol;
  logic              clockPha;
  logic [1:0]        rateSel;
  // Status flags and the clear qualifiers armed by status reads.
  logic              doneFlag;
  logic              wcolFlag;
  logic              modfFlag;
  logic              doneArmed;
  logic              wcolArmed;
  logic              modfArmed;
  // Datapath.
  logic [7:0]        shiftReg;
  logic [7:0]        rxBuffer;
  logic              next_txBit;
  logic [4:0]        edgeIdx;
  logic [5:0]        halfCnt;
  logic              pendStart;
  sps_mst_state_type mstState;
  logic [3:0]        slvBits;
  // Synchronised pins.
  logic [3:0]        pinSync;
  logic              sckS;
  logic              mosiS;
  logic              misoS;
  logic              ssS;
  logic              sckPrev;
  logic              ssPrev;
  // Decoded events.
  logic              ctrlWr;
  logic              statRd;
  logic              dataWr;
  logic              dataAcc;
  logic              busy;
  logic              slvActive;
  logic              slvEdge;
  logic              slvLead;
  logic              slvSample;
  logic              slvShift;
  logic              mstTick;
  logic              mstSample;
  logic              mstShift;
  logic              mstDone;
  logic              slvDone;
  logic              byteDone;
  logic              modeFault;
  logic              fifoReady;
  logic [7:0]        capByte;

  // Pin levels cross into ref_clk before any logic reads them.
  sps_sync #(
    .WIDTH (4)
  ) u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .asyncIn ({sckIn, mosiIn, misoIn, slaveSelectIn}),
    .syncOut (pinSync)
  );
  assign {sckS, mosiS, misoS, ssS} = pinSync;

  // Register decode on the two low address bits.
  assign ctrlWr  = busReq.sel && busReq.wr && (busReq.addr == CTRL_OFFSET[1:0]);
  assign statRd  = busReq.sel && busReq.rd && (busReq.addr == STATUS_OFFSET[1:0]);
  assign dataWr  = busReq.sel && busReq.wr && (busReq.addr == DATA_OFFSET[1:0]);
  assign dataAcc = busReq.sel && (busReq.wr || busReq.rd) &&
                   (busReq.addr == DATA_OFFSET[1:0]);

  // Slave timing: the clock is sampled, so SCK must be well below ref_clk/4.
  assign slvActive = sysEnable && !masterSel && !ssS;
  assign slvEdge   = slvActive && (sckS != sckPrev);
  assign slvLead   = (sckPrev == clockPol);
  assign slvSample = slvEdge && (slvLead != clockPha);
  assign slvShift  = slvEdge && (slvLead == clockPha);
  assign slvDone   = slvSample && (slvBits == 4'h7);

  // Master timing: one tick per SCK half period.
  assign mstTick   = (mstState == MST_XFER) && (halfCnt == halfPeriodLast(rateSel));
  assign mstSample = mstTick && (edgeIdx[0] == clockPha);
  assign mstShift  = mstTick && (edgeIdx[0] != clockPha);
  assign mstDone   = mstTick && (edgeIdx == LAST_EDGE);
  assign byteDone  = mstDone || slvDone;

  // Phase 0 blocks data writes for the whole selected period.
  assign busy = (mstState == MST_XFER) || pendStart ||
                (slvActive && (!clockPha || (slvBits != 4'h0)));

  assign modeFault = sysEnable && masterSel && !ssS;

  // Byte captured at the end: for the slave and master phase 1 the final sample lands in this same cycle.
  assign capByte = mstDone ? (mstSample ? {shiftReg[6:0], misoS} : shiftReg) :
                   {shiftReg[6:0], mosiS};

  // Control register; a mode fault overrides software in the same cycle.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqEnable <= CTRL_RESET[CTRL_IRQ_EN_BIT];
      sysEnable <= CTRL_RESET[CTRL_SYS_EN_BIT];
      masterSel <= CTRL_RESET[CTRL_MASTER_BIT];
      clockPol  <= CTRL_RESET[CTRL_CLOCK_POLARITY_BIT];
      clockPha  <= CTRL_RESET[CTRL_CLOCK_PHASE_BIT];
      rateSel   <= CTRL_RESET[CTRL_RATE_HI_BIT:CTRL_RATE_LO_BIT];
    end else begin
      if (ctrlWr) begin
        irqEnable <= busReq.wdata[CTRL_IRQ_EN_BIT];
        sysEnable <= busReq.wdata[CTRL_SYS_EN_BIT];
        masterSel <= busReq.wdata[CTRL_MASTER_BIT];
        clockPol  <= busReq.wdata[CTRL_CLOCK_POLARITY_BIT];
        clockPha  <= busReq.wdata[CTRL_CLOCK_PHASE_BIT];
        rateSel   <= busReq.wdata[CTRL_RATE_HI_BIT:CTRL_RATE_LO_BIT];
      end
      if (modeFault) begin
        masterSel <= 1'b0;
        sysEnable <= 1'b0;
      end
    end
  end

  // Status flags: hardware set wins over the two-step software clear.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      doneFlag  <= STATUS_RESET[STAT_DONE_BIT];
      wcolFlag  <= STATUS_RESET[STAT_WRITE_COLLISION_FLAG_BIT];
      modfFlag  <= STATUS_RESET[STAT_MODE_FAULT_FLAG_BIT];
      doneArmed <= 1'b0;
      wcolArmed <= 1'b0;
      modfArmed <= 1'b0;
    end else begin
      if (statRd) begin
        doneArmed <= doneFlag;
        wcolArmed <= wcolFlag;
        modfArmed <= modfFlag;
      end else begin
        if (dataAcc) begin
          doneArmed <= 1'b0;
          wcolArmed <= 1'b0;
        end
        if (ctrlWr) begin
          modfArmed <= 1'b0;
        end
      end
      if (byteDone) begin
        doneFlag <= 1'b1;
      end else if (dataAcc && doneArmed && !statRd) begin
        doneFlag <= 1'b0;
      end
      if (dataWr && busy) begin
        wcolFlag <= 1'b1;
      end else if (dataAcc && wcolArmed && !statRd) begin
        wcolFlag <= 1'b0;
      end
      if (modeFault) begin
        modfFlag <= 1'b1;
      end else if (ctrlWr && modfArmed && !statRd) begin
        modfFlag <= 1'b0;
      end
    end
  end

  // Master sequencer: a write arms a start that waits for FIFO room.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mstState  <= MST_IDLE;
      pendStart <= 1'b0;
      halfCnt   <= 6'h00;
      edgeIdx   <= 5'h00;
    end else begin
      case (mstState)
        MST_IDLE: begin
          halfCnt <= 6'h00;
          edgeIdx <= 5'h00;
          if (!(sysEnable && masterSel) || modeFault) begin
            pendStart <= 1'b0;
          end else if (dataWr && !busy) begin
            pendStart <= 1'b1;
          end else if (pendStart && fifoReady) begin
            pendStart <= 1'b0;
            mstState  <= MST_XFER;
          end
        end
        MST_XFER: begin
          if (modeFault || !sysEnable) begin
            mstState <= MST_IDLE;
          end else if (mstTick) begin
            halfCnt <= 6'h00;
            edgeIdx <= edgeIdx + 5'h01;
            if (mstDone) begin
              mstState <= MST_IDLE;
            end
          end else begin
            halfCnt <= halfCnt + 6'h01;
          end
        end
        default: mstState <= MST_IDLE;
      endcase
    end
  end

  // Slave byte counter; deselect restarts byte framing.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      slvBits <= 4'h0;
      sckPrev <= 1'b0;
      ssPrev  <= 1'b1;
    end else begin
      sckPrev <= sckS;
      ssPrev  <= ssS;
      if (!slvActive || slvDone) begin
        slvBits <= 4'h0;
      end else if (slvSample) begin
        slvBits <= slvBits + 4'h1;
      end
    end
  end

  // Shift ring: sample into the LSB, present the MSB; the byte keeps its bit order.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      shiftReg <= 8'h00;
    end else if (dataWr && !busy) begin
      shiftReg <= busReq.wdata;
    end else if (mstSample) begin
      shiftReg <= {shiftReg[6:0], misoS};
    end else if (slvSample) begin
      shiftReg <= {shiftReg[6:0], mosiS};
    end
  end

  // Next serial bit; the pin flops load it directly, so data leads SCK by half a period.
  always_comb begin
    next_txBit = mosiOut;
    if (mstState == MST_IDLE && !slvActive) begin
      next_txBit = (pendStart && fifoReady && !clockPha) ? shiftReg[7] : 1'b1;
    end else if (mstDone) begin
      next_txBit = 1'b1;
    end else if (mstShift || slvShift) begin
      next_txBit = shiftReg[7];
    end else if (slvActive && ssPrev && !clockPha) begin
      next_txBit = shiftReg[7];
    end
  end

  // Receive buffer loads in the cycle the completion flag sets.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxBuffer <= 8'h00;
    end else if (byteDone) begin
      rxBuffer <= capByte;
    end
  end

  // Pin drivers; with the port disabled every pin is an input.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sckOut          <= 1'b0;
      sckOe           <= 1'b0;
      mosiOut         <= 1'b1;
      mosiOe          <= 1'b0;
      misoOut         <= 1'b1;
      misoOe          <= 1'b0;
      portCLowPinsSel <= 1'b0;
    end else begin
      portCLowPinsSel <= sysEnable && !modeFault;
      sckOe           <= sysEnable && masterSel && !modeFault;
      mosiOe          <= sysEnable && masterSel && !modeFault;
      misoOe          <= slvActive;
      mosiOut         <= next_txBit;
      misoOut         <= next_txBit;
      if (mstState == MST_XFER && mstTick && !mstDone) begin
        sckOut <= ~sckOut;
      end else if (mstState != MST_XFER || mstDone) begin
        sckOut <= clockPol;
      end
    end
  end

  // Register read data and the interrupt request, both registered.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 8'h00;
      irqReq   <= 1'b0;
    end else begin
      irqReq <= irqEnable && !cpuIrqMask && (doneFlag || modfFlag);
      if (busReq.sel && busReq.rd) begin
        if (busReq.addr == CTRL_OFFSET[1:0]) begin
          regRdata <= {irqEnable, sysEnable, 1'b0, masterSel,
                       clockPol, clockPha, rateSel};
        end else if (busReq.addr == STATUS_OFFSET[1:0]) begin
          regRdata <= {doneFlag, wcolFlag, 1'b0, modfFlag, 4'h0};
        end else if (busReq.addr == DATA_OFFSET[1:0]) begin
          regRdata <= rxBuffer;
        end else begin
          regRdata <= 8'h00;
        end
      end
    end
  end

  // Stream copy of received bytes; a full FIFO holds off master starts and drops slave bytes.
  sps_fifo #(
    .WIDTH (BYTE_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .inValid  (byteDone),
    .inReady  (fifoReady),
    .inData   (capByte),
    .outValid (rxStreamValid),
    .outReady (rxStreamReady),
    .outData  (rxStreamData)
  );

endmodule // sps_port
`default_nettype wire

// ===== sps_port_asserts.sv
// Purpose: Port-level timing checks for the serial port.
// Assumes: One clock domain; pins are driven by the bench.
// Notes:   Bound to every instance of the port.
`timescale 1ns/1ps
`default_nettype none
module sps_port_asserts
  import sps_pkg::*;
(
  // Clock and reset
  input wire logic            ref_clk,
  input wire logic            arst_n,
  // Watched ports
  input wire sps_bus_req_type busReq,
  input wire logic [7:0]      regRdata,
  input wire logic            cpuIrqMask,
  input wire logic            irqReq,
  input wire logic            sckOe,
  input wire logic            mosiOut,
  input wire logic            mosiOe,
  input wire logic            misoOe,
  input wire logic            slaveSelectIn,
  input wire logic            portCLowPinsSel,
  input wire logic            rxStreamValid,
  input wire logic            rxStreamReady,
  input wire logic [7:0]      rxStreamData
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Select pulled low for three cycles while acting as master.
  sequence ss_low_as_master;
    sckOe && !slaveSelectIn ##1 !slaveSelectIn [*2];
  endsequence
  // Pin synchronisers add two cycles, so the fault window allows four.
  a_mode_fault: assert property (ss_low_as_master |-> ##[0:4] !portCLowPinsSel && !sckOe)
    else $error("mode fault did not release the pins");
  a_master_pins: assert property (sckOe |-> mosiOe && !misoOe)
    else $error("master pin directions wrong");
  a_deselect_float: assert property (slaveSelectIn [*5] |-> !misoOe)
    else $error("deselected port drives miso");
  a_enable_idle: assert property ($rose(sckOe) |-> mosiOut && portCLowPinsSel)
    else $error("enabled master not idle high");
  a_irq_masked: assert property (cpuIrqMask |=> !irqReq)
    else $error("interrupt despite mask");
  a_unmapped_zero: assert property (busReq.sel && busReq.rd && busReq.addr == 2'h3
    |=> regRdata == 8'h00) else $error("unmapped read nonzero");
  a_rdata_holds: assert property (!(busReq.sel && busReq.rd) |=> $stable(regRdata))
    else $error("read data moved without a read");
  a_stream_holds: assert property (rxStreamValid && !rxStreamReady
    |=> rxStreamValid && $stable(rxStreamData)) else $error("stream dropped a byte");
endmodule // sps_port_asserts
bind sps_port sps_port_asserts chk_u (.ref_clk, .arst_n, .busReq, .regRdata, .cpuIrqMask,
  .irqReq, .sckOe, .mosiOut, .mosiOe, .misoOe, .slaveSelectIn, .portCLowPinsSel,
  .rxStreamValid, .rxStreamReady, .rxStreamData);
`default_nettype wire

// ===== sps_slave_model.sv
// Purpose: Far-end slave for the port in master mode.
// Assumes: Polarity 0, phase 0, the same format the bench programs.
// Notes:   Deselected, miso shows the inverse of the last bit.
`timescale 1ns/1ps
`default_nettype none
module sps_slave_model (
  // Pins
  input wire logic        sck,
  input wire logic        mosi,
  input wire logic        ssN,
  output logic            miso,
  // Payload
  input wire logic [7:0]  txByte,
  output logic     [7:0]  rxByte
);
  logic [7:0] shiftReg;
  // Select loads the byte so the first bit leads the first edge.
  always @(negedge ssN) shiftReg = txByte;
  // Sample on the rising edge, shift on the falling one, MSB first.
  always @(posedge sck) if (!ssN) rxByte = {rxByte[6:0], mosi};
  always @(negedge sck) if (!ssN) shiftReg = {shiftReg[6:0], 1'b0};
  // A released line must not look like valid data.
  assign miso = ssN ? ~shiftReg[7] : shiftReg[7];
endmodule // sps_slave_model
`default_nettype wire

// ===== spi_master_slave_port_tb_top.sv
// Purpose: Self-checking bench for the port as master and slave.
// Assumes: Far end is the phase 0 slave model.
// Notes:   The stream is drained only at the end, so bytes queue up.
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_port_tb_top;
  import sps_pkg::*;
  logic            ref_clk = 1'b0;
  logic            arst_n = 1'b0;
  logic            cpuIrqMask = 1'b0;
  logic            slaveSelectIn = 1'b1;
  logic            modelSsN = 1'b1;
  logic            rxStreamReady = 1'b0;
  logic            benchSck = 1'b1;
  logic            benchMosi = 1'b1;
  sps_bus_req_type busReq = '0;
  logic [7:0]      modelTx = 8'h00;
  logic [7:0]      regRdata, rxStreamData, modelRx, rd;
  logic            sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, misoPin;
  logic            irqReq, portCLowPinsSel, rxStreamValid;
  int              mismatches = 0;
  int              checks = 0;
  int              xfers = 0;
  logic [5:0]      divs [4] = '{DIV_CODE0, DIV_CODE1, DIV_CODE2, DIV_CODE3};

  // Clock at 250 MHz.
  initial forever #2 ref_clk = ~ref_clk;

  // Undriven pins show the bench's own master drive; miso shows the far-end model.
  sps_port dut_u (.ref_clk, .arst_n, .busReq, .regRdata, .cpuIrqMask, .irqReq,
    .sckIn(sckOe ? sckOut : benchSck), .sckOut, .sckOe, .mosiIn(mosiOe ? mosiOut : benchMosi),
    .mosiOut, .mosiOe, .misoIn(misoOe ? misoOut : misoPin), .misoOut, .misoOe,
    .slaveSelectIn, .portCLowPinsSel, .rxStreamValid, .rxStreamReady, .rxStreamData);
  sps_slave_model peer_u (.sck(sckOut), .mosi(mosiOut), .ssN(modelSsN), .miso(misoPin),
    .txByte(modelTx), .rxByte(modelRx));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One register access; a read result is kept in rd.
  task automatic acc(input logic [1:0] a, input logic w, input logic [7:0] d);
    @(posedge ref_clk);
    busReq <= '{sel: 1'b1, addr: a, wr: w, rd: !w, wdata: d};
    @(posedge ref_clk);
    busReq <= '0;
    #1 rd = regRdata;
  endtask
  // Bounded waits; running out ends the run.
  task automatic wait_sck(input logic v, output int n);
    n = 0;
    while (sckOut !== v && n < 100) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n >= 100) begin
      mismatches++;
      summarize();
    end
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      acc(2'h1, 1'b0, 8'h00);
      n++;
    end while (rd[7] !== 1'b1 && n < 400);
    if (n >= 400) begin
      mismatches++;
      summarize();
    end
  endtask

  task automatic t_reset();
    acc(2'h0, 1'b0, 8'h00);
    chk(rd & 8'hfc, 8'h04);
    acc(2'h1, 1'b0, 8'h00);
    chk(rd, 8'h00);
    acc(2'h3, 1'b0, 8'h00);
    chk(rd, 8'h00);
    $display("reset values done");
  endtask
  // Master byte exchange at one rate code, interrupt enabled.
  task automatic t_xfer(input logic [1:0] code);
    int a, b;
    modelTx = 8'h3c ^ {6'h00, code};
    acc(2'h0, 1'b1, {6'h34, code});
    chk({7'h00, mosiOut}, 8'h01);
    @(posedge ref_clk) modelSsN <= 1'b0;
    acc(2'h2, 1'b1, 8'ha5 ^ {6'h00, code});
    wait_sck(1'b1, a);
    wait_sck(1'b0, a);
    wait_sck(1'b1, b);
    chk(8'(a + b), {2'h0, divs[code]});
    wait_done();
    chk(rd, 8'h80);
    chk({7'h00, irqReq}, 8'h01);
    @(posedge ref_clk) cpuIrqMask <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk({7'h00, irqReq}, 8'h00);
    @(posedge ref_clk) cpuIrqMask <= 1'b0;
    @(posedge ref_clk) modelSsN <= 1'b1;
    acc(2'h2, 1'b0, 8'h00);
    if (code[1]) chk(rd, modelTx);
    chk(modelRx, 8'ha5 ^ {6'h00, code});
    acc(2'h1, 1'b0, 8'h00);
    chk(rd, 8'h00);
    xfers++;
    $display("transfer at rate %0d done", code);
  endtask
  task automatic t_collision();
    @(posedge ref_clk) modelSsN <= 1'b0;
    acc(2'h2, 1'b1, 8'h5a);
    acc(2'h2, 1'b1, 8'hff);
    wait_done();
    chk(rd, 8'hc0);
    @(posedge ref_clk) modelSsN <= 1'b1;
    chk(modelRx, 8'h5a);
    acc(2'h2, 1'b0, 8'h00);
    acc(2'h1, 1'b0, 8'h00);
    chk(rd, 8'h00);
    xfers++;
    $display("write collision done");
  endtask
  task automatic t_fault();
    @(posedge ref_clk) slaveSelectIn <= 1'b0;
    repeat (6) @(posedge ref_clk);
    slaveSelectIn <= 1'b1;
    acc(2'h0, 1'b0, 8'h00);
    chk(rd & 8'h50, 8'h00);
    chk({7'h00, irqReq}, 8'h01);
    acc(2'h1, 1'b0, 8'h00);
    chk(rd, 8'h10);
    acc(2'h0, 1'b1, 8'h00);
    acc(2'h1, 1'b0, 8'h00);
    chk(rd, 8'h00);
    $display("mode fault done");
  endtask
  task automatic t_slave();
    acc(2'h0, 1'b1, 8'h40);
    repeat (6) @(posedge ref_clk);
    #1 chk({7'h00, misoOe}, 8'h00);
    @(posedge ref_clk) slaveSelectIn <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1 chk({7'h00, misoOe}, 8'h01);
    acc(2'h2, 1'b1, 8'h11);
    acc(2'h1, 1'b0, 8'h00);
    chk(rd, 8'h40);
    @(posedge ref_clk) slaveSelectIn <= 1'b1;
    $display("slave select done");
  endtask
  // Slave byte at polarity 1, phase 1; the bench is master at nine clocks per SCK period.
  task automatic t_slave_xfer();
    logic [7:0] sent;
    logic [7:0] got;
    sent = 8'h96;
    got = 8'h00;
    acc(2'h0, 1'b1, 8'h4f);
    acc(2'h2, 1'b1, 8'hc3);
    @(posedge ref_clk) slaveSelectIn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int i = 7; i >= 0; i--) begin
      benchSck <= 1'b0;
      benchMosi <= sent[i];
      repeat (4) @(posedge ref_clk);
      #1 got = {got[6:0], misoOut};
      @(posedge ref_clk) benchSck <= 1'b1;
      repeat (4) @(posedge ref_clk);
    end
    acc(2'h1, 1'b0, 8'h00);
    chk(rd, 8'h80);
    acc(2'h2, 1'b0, 8'h00);
    chk(rd, sent);
    chk(got, 8'hc3);
    @(posedge ref_clk) slaveSelectIn <= 1'b1;
    xfers++;
    $display("slave transfer done");
  endtask
  task automatic t_drain();
    logic [7:0] want [6];
    int n;
    want = '{8'h00, 8'h00, 8'h3e, 8'h3f, 8'h3f, 8'h96};
    n = 0;
    @(posedge ref_clk) rxStreamReady <= 1'b1;
    repeat (40) begin
      #1 if (rxStreamValid === 1'b1) begin
        if (n >= 2 && n < 6) chk(rxStreamData, want[n]);
        n++;
      end
      @(posedge ref_clk);
    end
    chk(8'(n), 8'(xfers));
    $display("stream drain done");
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset();
    for (int c = 0; c < 4; c++) t_xfer(2'(c));
    t_collision();
    t_fault();
    t_slave();
    t_slave_xfer();
    t_drain();
    summarize();
  end
endmodule // spi_master_slave_port_tb_top
`default_nettype wire
